/* include/synth_latch_pkg.sv */
// Purpose: Shared constants for the synthesizer latch control block
// Assumes: 24-bit serial words, two select bits in the low end of the word
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package synth_latch_pkg;
    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam int CUR_W = 3;
    localparam int PRE_W = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Select codes in the low two bits of each word
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_MAIN = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    // Function and initialization latch field positions
    localparam int SEL_LSB = 0;
    localparam int CNT_RST_BIT = 2;
    localparam int PD_A_BIT = 3;
    localparam int PD_POL_BIT = 7;
    localparam int PUMP_TRI_BIT = 8;
    localparam int PRI_LSB = 15;
    localparam int SEC_LSB = 18;
    localparam int PD_B_BIT = 21;
    localparam int PRE_LSB = 22;
    localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;

    // Register map
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_REF = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MAIN = 8'h10;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000001;
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int ST_POWER_DOWN_BIT = 0;
    localparam int ST_HOLD_BIT = 1;
    localparam int ST_TRI_BIT = 2;
    localparam int ST_ARMED_BIT = 3;
    localparam int ST_CE_BIT = 4;
    localparam int ST_SYNC_PD_BIT = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/synth_latch_init_control.sv */
// Purpose: Serial configuration latches, initialization pulse and power-down control
// Assumes: serial_clk stops while latch_strobe is high; pump_event is on aclk
// Notes: Latches are cleared only by aresetn, never by chip enable
// What this block does
// - Two three-bit fields select pump currents
// - Function bit selects phase detector polarity
// - Three-state bit high floats pump output
// - Code 11 loads initialization latch, 10 function
// - Initialization loads function, pulses counter reset
// - Initialization pulse sets synchronous power-down only with pd_a high, pd_b low
// - First main word after initialization pulses again
// - Code 00 reference latch, 01 main latch
// - Chip enable low powers down asynchronously
// - Load while chip enable low, restart aligned
// - Configuration survives chip-enable power cycles
// - Reset bit holds counters, no pump-event synchronous power-down
// - 24 bits shifted, strobe routes by select
// - Counter reset bit at data bit 2
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module synth_latch_init_control
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [synth_latch_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [synth_latch_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [synth_latch_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [synth_latch_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic pump_event,
    output logic [synth_latch_pkg::CUR_W-1:0] primary_current,
    output logic [synth_latch_pkg::CUR_W-1:0] secondary_current,
    output logic [synth_latch_pkg::PRE_W-1:0] prescaler_sel,
    output logic pd_polarity,
    output logic pump_output_oe_n,
    output logic counters_hold,
    output logic counter_reset_pulse,
    output logic power_down,
    output logic [synth_latch_pkg::WORD_W-1:0] ref_word,
    output logic [synth_latch_pkg::WORD_W-1:0] main_word
);
    localparam int W = synth_latch_pkg::WORD_W;
    localparam int D = synth_latch_pkg::DATA_W;
    localparam int EN = synth_latch_pkg::CTRL_LINK_EN_BIT;

    function automatic logic is_sel(input logic [W-1:0] word, input logic [1:0] code);
        return word[synth_latch_pkg::SEL_LSB +: synth_latch_pkg::SEL_W] == code;
    endfunction

    // Link domain: input register shifted on rising serial clock
    logic [W-1:0] shift_r, shift_nxt;

    always_comb
    begin
        shift_nxt = {shift_r[W-2:0], serial_data};
    end

    always_ff @(posedge serial_clk)
    begin
        shift_r <= shift_nxt;
    end

    // Pin synchronisers; the first stage feeds only the second
    logic strobe_s1_r, strobe_s2_r, strobe_s3_r;
    logic ce_s1_r, ce_s2_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strobe_s1_r <= 1'b0;
            strobe_s2_r <= 1'b0;
            strobe_s3_r <= 1'b0;
            ce_s1_r <= 1'b0;
            ce_s2_r <= 1'b0;
        end
        else if (clk_en)
        begin
            strobe_s1_r <= latch_strobe;
            strobe_s2_r <= strobe_s1_r;
            strobe_s3_r <= strobe_s2_r;
            ce_s1_r <= chip_enable;
            ce_s2_r <= ce_s1_r;
        end
    end

    // Register bus state
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [synth_latch_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [D-1:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [D-1:0] rdata_r, rdata_nxt, ctrl_r, ctrl_nxt;

    // Latch state
    logic [W-1:0] func_r, func_nxt, ref_r, ref_nxt, main_r, main_nxt;
    logic armed_r, armed_nxt, pulse_r, pulse_nxt;
    logic sync_pd_r, sync_pd_nxt, pd_r, pd_nxt;
    logic word_ev;
    logic [W-1:0] word;
    logic cnt_rst, pd_a, pd_b, hold, tri_st;
    logic [D-1:0] status;

    assign word = shift_r;
    // The word is stable once the strobe is high, so the synced edge qualifies it
    assign word_ev = strobe_s2_r & ~strobe_s3_r & ctrl_r[synth_latch_pkg::CTRL_LINK_EN_BIT];
    assign cnt_rst = func_r[synth_latch_pkg::CNT_RST_BIT];
    assign pd_a = func_r[synth_latch_pkg::PD_A_BIT];
    assign pd_b = func_r[synth_latch_pkg::PD_B_BIT];
    assign hold = pd_r | ~ce_s2_r | cnt_rst | pulse_r;
    assign tri_st = func_r[synth_latch_pkg::PUMP_TRI_BIT] | hold;

    always_comb
    begin
        status = '0;
        status[synth_latch_pkg::ST_POWER_DOWN_BIT] = pd_r | ~ce_s2_r;
        status[synth_latch_pkg::ST_HOLD_BIT] = hold;
        status[synth_latch_pkg::ST_TRI_BIT] = tri_st;
        status[synth_latch_pkg::ST_ARMED_BIT] = armed_r;
        status[synth_latch_pkg::ST_CE_BIT] = ce_s2_r;
        status[synth_latch_pkg::ST_SYNC_PD_BIT] = sync_pd_r;
    end

    always_comb
    begin
        func_nxt = func_r;
        ref_nxt = ref_r;
        main_nxt = main_r;
        armed_nxt = armed_r;
        pulse_nxt = 1'b0;
        if (word_ev)
        begin
            // Loads proceed with chip enable low; the input register stays active
            if (is_sel(word, synth_latch_pkg::SEL_FUNC) ||
                is_sel(word, synth_latch_pkg::SEL_INIT))
            begin
                func_nxt = word;
            end
            if (is_sel(word, synth_latch_pkg::SEL_INIT))
            begin
                pulse_nxt = 1'b1;
                armed_nxt = 1'b1;
            end
            if (is_sel(word, synth_latch_pkg::SEL_REF))
            begin
                ref_nxt = word;
            end
            if (is_sel(word, synth_latch_pkg::SEL_MAIN))
            begin
                main_nxt = word;
                pulse_nxt = armed_r;
                armed_nxt = 1'b0;
            end
        end
    end

    always_comb
    begin
        sync_pd_nxt = sync_pd_r;
        if (!pd_a)
        begin
            sync_pd_nxt = 1'b0;
        end
        // Gated by a pump event so the loop does not jump
        if (pd_a && pd_b && pump_event && !cnt_rst && ce_s2_r)
        begin
            sync_pd_nxt = 1'b1;
        end
        if (pulse_r && ce_s2_r && pd_a && !pd_b)
        begin
            sync_pd_nxt = 1'b1;
        end
        pd_nxt = sync_pd_nxt | (pd_a & ~pd_b);
    end

    always_comb
    begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ctrl_nxt = ctrl_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !bvalid_r)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = synth_latch_pkg::RESP_SLVERR;
            if (aw_addr_r == synth_latch_pkg::OFS_CTRL)
            begin
                ctrl_nxt = {{(D-1){1'b0}}, (w_strb_r[0] ? w_data_r[EN] : ctrl_r[EN])};
                bresp_nxt = synth_latch_pkg::RESP_OKAY;
            end
            else if (aw_addr_r == synth_latch_pkg::OFS_STATUS ||
                     aw_addr_r == synth_latch_pkg::OFS_FUNC ||
                     aw_addr_r == synth_latch_pkg::OFS_REF ||
                     aw_addr_r == synth_latch_pkg::OFS_MAIN)
            begin
                // Read-only registers accept and ignore the write
                bresp_nxt = synth_latch_pkg::RESP_OKAY;
            end
        end
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = synth_latch_pkg::RESP_OKAY;
            case (s_axi_araddr)
                synth_latch_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
                synth_latch_pkg::OFS_STATUS: rdata_nxt = status;
                synth_latch_pkg::OFS_FUNC: rdata_nxt = {8'h00, func_r};
                synth_latch_pkg::OFS_REF: rdata_nxt = {8'h00, ref_r};
                synth_latch_pkg::OFS_MAIN: rdata_nxt = {8'h00, main_r};
                default:
                begin
                    rdata_nxt = '0;
                    rresp_nxt = synth_latch_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= synth_latch_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= synth_latch_pkg::RESP_OKAY;
            ctrl_r <= synth_latch_pkg::CTRL_RST;
            func_r <= synth_latch_pkg::LATCH_RST;
            ref_r <= synth_latch_pkg::LATCH_RST;
            main_r <= synth_latch_pkg::LATCH_RST;
            armed_r <= 1'b0;
            pulse_r <= 1'b0;
            sync_pd_r <= 1'b0;
            pd_r <= 1'b0;
        end
        else if (clk_en)
        begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            ctrl_r <= ctrl_nxt;
            // Chip enable never touches the latches, so settings survive power cycles
            func_r <= func_nxt;
            ref_r <= ref_nxt;
            main_r <= main_nxt;
            armed_r <= armed_nxt;
            pulse_r <= pulse_nxt;
            sync_pd_r <= sync_pd_nxt;
            pd_r <= pd_nxt;
        end
    end

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    assign primary_current = func_r[synth_latch_pkg::PRI_LSB +: synth_latch_pkg::CUR_W];
    assign secondary_current = func_r[synth_latch_pkg::SEC_LSB +: synth_latch_pkg::CUR_W];
    assign prescaler_sel = func_r[synth_latch_pkg::PRE_LSB +: synth_latch_pkg::PRE_W];
    assign pd_polarity = func_r[synth_latch_pkg::PD_POL_BIT];
    assign counter_reset_pulse = pulse_r;
    assign ref_word = ref_r;
    assign main_word = main_r;
    // The raw pin bypasses the synchroniser so disable takes effect at once
    assign power_down = pd_r | ~chip_enable;
    assign counters_hold = hold | ~chip_enable;
    assign pump_output_oe_n = tri_st | ~chip_enable;
endmodule

/* test/synth_latch_monitor.sv */
// Purpose: Port checks for the latch control block
// Assumes: Loads land within a few aclk cycles of a strobe
// Notes: Strobe age saturates so long idle spans never wrap
`timescale 1ns/1ns
module synth_latch_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic latch_strobe,
    input wire logic chip_enable,
    input wire logic [2:0] primary_current,
    input wire logic [2:0] secondary_current,
    input wire logic [1:0] prescaler_sel,
    input wire logic pd_polarity,
    input wire logic pump_output_oe_n,
    input wire logic counters_hold,
    input wire logic counter_reset_pulse,
    input wire logic power_down,
    input wire logic [23:0] ref_word,
    input wire logic [23:0] main_word
);
    logic [3:0] stb_age_r;
    logic [3:0] stb_age_nxt;

    always_comb
    begin
        stb_age_nxt = stb_age_r;
        if (latch_strobe)
            stb_age_nxt = 4'h0;
        else if (stb_age_r != 4'hf)
            stb_age_nxt = stb_age_r + 4'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stb_age_r <= 4'hf;
        else
            stb_age_r <= stb_age_nxt;
    end

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_ce_low_down: assert property (!chip_enable |-> power_down && counters_hold && pump_output_oe_n)
        else $error("chip enable low without power-down");
    a_hold_floats: assert property (counters_hold |-> pump_output_oe_n)
        else $error("counters held but pump driven");
    a_pulse_single: assert property (counter_reset_pulse |=> !counter_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_pulse_holds: assert property (counter_reset_pulse |-> counters_hold)
        else $error("reset pulse without counter hold");
    a_pd_holds: assert property (power_down |-> counters_hold)
        else $error("power-down without counter hold");
    a_pulse_on_load: assert property (counter_reset_pulse |-> stb_age_r < 4'h6)
        else $error("reset pulse without a strobe");
    a_cfg_on_load: assert property (
        $changed({primary_current, secondary_current, prescaler_sel, pd_polarity})
        |-> stb_age_r < 4'h6)
        else $error("function outputs changed without a strobe");
    a_words_on_load: assert property ($changed({ref_word, main_word}) |-> stb_age_r < 4'h6)
        else $error("divider word changed without a strobe");
    a_ce_rise_hold: assert property ($rose(chip_enable) |-> counters_hold ##1 counters_hold)
        else $error("counters released before enable was synchronised");

    c_pulse: cover property (counter_reset_pulse);
    c_soft_pd: cover property (power_down && chip_enable);
    c_reset_bit_hold: cover property (counters_hold && !power_down && stb_age_r == 4'hf);
endmodule

bind synth_latch_init_control synth_latch_monitor u_mon
(
    .aclk, .aresetn, .latch_strobe, .chip_enable, .primary_current, .secondary_current,
    .prescaler_sel, .pd_polarity, .pump_output_oe_n, .counters_hold, .counter_reset_pulse,
    .power_down, .ref_word, .main_word
);

/* test/serial_host.sv */
// Purpose: Host model that shifts words into the latch link
// Assumes: Link clock idles low between frames
// Notes: Data shows the inverse of its last bit once a frame ends
`timescale 1ns/1ns
module serial_host
(
    output logic serial_clk,
    output logic serial_data,
    output logic latch_strobe
);
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_strobe = 1'b0;
    end

    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            serial_data = w[i];
            #62 serial_clk = 1'b1;
            #63 serial_clk = 1'b0;
        end
        serial_data = ~serial_data;
        #40 latch_strobe = 1'b1;
        #100 latch_strobe = 1'b0;
        #100;
    endtask
endmodule

/* test/synth_latch_init_control_tb.sv */
// Purpose: Self-checking bench for the latch control block
// Assumes: serial_host shifts words; registers over AXI4-Lite
// Notes: Pulses are counted so each load method is judged by totals
`timescale 1ns/1ns
module synth_latch_init_control_tb;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, chip_enable = 1'b1, pump_event = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, prescaler_sel, r;
    logic [31:0] s_axi_rdata, d;
    logic serial_clk, serial_data, latch_strobe;
    logic [2:0] primary_current, secondary_current;
    logic pd_polarity, pump_output_oe_n, counters_hold, counter_reset_pulse, power_down;
    logic [23:0] ref_word, main_word, wf;
    int failures = 0, n_tests = 0, n_pulse = 0;

    serial_host host (.serial_clk, .serial_data, .latch_strobe);
    synth_latch_init_control uut
    (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .serial_clk, .serial_data, .latch_strobe, .chip_enable,
        .pump_event, .primary_current, .secondary_current, .prescaler_sel, .pd_polarity,
        .pump_output_oe_n, .counters_hold, .counter_reset_pulse, .power_down, .ref_word,
        .main_word
    );

    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (counter_reset_pulse === 1'b1)
            n_pulse <= n_pulse + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        dt = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Flags are {pd_b, pd_a, counter reset, three-state, polarity}
    function automatic logic [23:0] fw(input logic [1:0] sel, input logic [2:0] pri,
        input logic [2:0] sec, input logic [1:0] pre, input logic [4:0] f);
        logic [23:0] w;
        w = {22'h0, sel};
        w[synth_latch_pkg::PRI_LSB +: 3] = pri;
        w[synth_latch_pkg::SEC_LSB +: 3] = sec;
        w[synth_latch_pkg::PRE_LSB +: 2] = pre;
        w[synth_latch_pkg::PD_POL_BIT] = f[0];
        w[synth_latch_pkg::PUMP_TRI_BIT] = f[1];
        w[synth_latch_pkg::CNT_RST_BIT] = f[2];
        w[synth_latch_pkg::PD_A_BIT] = f[3];
        w[synth_latch_pkg::PD_B_BIT] = f[4];
        return w;
    endfunction

    task automatic ld(input logic [23:0] w);
        host.send(w);
        @(posedge aclk);
    endtask

    task automatic pump_tick;
        pump_event <= 1'b1;
        @(posedge aclk);
        pump_event <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic give_verdict;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(synth_latch_pkg::OFS_CTRL, d, r);
        chk(d, synth_latch_pkg::CTRL_RST);
        axi_wr(8'h40, 32'h00000001, r);
        chk(r, synth_latch_pkg::RESP_SLVERR);
        axi_rd(8'h40, d, r);
        chk(r, synth_latch_pkg::RESP_SLVERR);
        axi_wr(synth_latch_pkg::OFS_FUNC, 32'h00ffffff, r);
        chk(r, synth_latch_pkg::RESP_OKAY);
        chip_enable <= 1'b0;
        repeat (2) @(posedge aclk);
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h7);
        wf = fw(2'h2, 3'h5, 3'h2, 2'h1, 5'h01);
        ld(wf);
        ld(24'h001234);
        ld(24'h012345);
        chk({primary_current, secondary_current, prescaler_sel, pd_polarity}, 9'h153);
        chk(ref_word, 24'h001234);
        chk(main_word, 24'h012345);
        chk(n_pulse, 0);
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h7);
        chip_enable <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h0);
        repeat (100) @(posedge aclk);
        axi_rd(synth_latch_pkg::OFS_FUNC, d, r);
        chk(d, {8'h00, wf});
        chip_enable <= 1'b0;
        repeat (3) @(posedge aclk);
        chip_enable <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({primary_current, secondary_current, prescaler_sel, pd_polarity}, 9'h153);
        ld(fw(2'h3, 3'h3, 3'h6, 2'h2, 5'h00));
        chk(n_pulse, 1);
        chk({primary_current, secondary_current, prescaler_sel, pd_polarity}, 9'h0f4);
        ld(fw(2'h2, 3'h3, 3'h6, 2'h2, 5'h00));
        ld(24'h000020);
        chk(n_pulse, 1);
        ld(24'h000041);
        chk(n_pulse, 2);
        ld(24'h000081);
        chk(n_pulse, 2);
        chk(main_word, 24'h000081);
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h04));
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h3);
        ld(24'h000100);
        ld(24'h000101);
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h3);
        chk(n_pulse, 2);
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h00));
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h0);
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h02));
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h1);
        ld(fw(2'h3, 3'h1, 3'h7, 2'h3, 5'h08));
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h7);
        chk(n_pulse, 3);
        axi_rd(synth_latch_pkg::OFS_STATUS, d, r);
        chk(d, 32'h0000003f);
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h00));
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h1c));
        pump_tick();
        axi_rd(synth_latch_pkg::OFS_STATUS, d, r);
        chk(d, 32'h0000001e);
        ld(fw(2'h2, 3'h1, 3'h7, 2'h3, 5'h18));
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h0);
        pump_tick();
        chk({power_down, counters_hold, pump_output_oe_n}, 3'h7);
        axi_wr(synth_latch_pkg::OFS_CTRL, 32'h00000000, r);
        chk(r, synth_latch_pkg::RESP_OKAY);
        ld(24'h000ff0);
        chk(ref_word, 24'h000100);
        give_verdict();
    end

    // Loads take about 3.25 us each; the limit leaves ample margin
    initial
    begin
        #300000;
        failures = failures + 1;
        give_verdict();
    end
endmodule
